// >>> rtl/prbs_check_and_event_irq.sv
// Datapath pattern checker with chip, lane and link event request logic
`timescale 1ns/100ps
module prbs_check_and_event_irq (
  input wire logic clk,
  input wire logic sys_rst,
  input wire prbs_irq_pkg::reg_req_s reg_req,
  output logic [prbs_irq_pkg::DATA_W-1:0] reg_rdata,
  input wire prbs_irq_pkg::dp_group_s dp_group,
  input wire logic [prbs_irq_pkg::CHIP_EVENTS-1:0] chip_event_in,
  input wire logic [prbs_irq_pkg::LANE_EVENTS-1:0] lane_event_in,
  input wire logic [prbs_irq_pkg::LINK_EVENTS-1:0] link_event_in,
  input wire logic extra_event_in,
  output logic irq_n_out,
  output logic irq_n_oe
);
  import prbs_irq_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Self-synchronising check: each new bit is predicted from received bits
  function automatic logic group_bad(input logic [GROUP_W-1:0] prev,
                                     input logic [GROUP_W-1:0] cur,
                                     input logic sel);
    logic [2*GROUP_W-1:0] s;
    logic bad;
    int ta;
    int tb;
    s = {cur, prev};
    bad = 1'b0;
    ta = sel ? PRBS15_TAP_A : PRBS7_TAP_A;
    tb = sel ? PRBS15_TAP_B : PRBS7_TAP_B;
    for (int j = GROUP_W; j < 2 * GROUP_W; j++)
      bad = bad | (s[j] ^ s[j - ta] ^ s[j - tb]);
    return bad;
  endfunction : group_bad

  // Saturating count so a busy link never wraps back to a clean reading
  function automatic logic [DATA_W-1:0] sat_inc(input logic [DATA_W-1:0] v);
    return (&v) ? v : DATA_W'(v + 1'b1);
  endfunction : sat_inc

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [CHIP_EVENTS-1:0] chip_en_reg;
  logic [DATA_W-1:0] link_en_reg;
  logic extra_en_reg;
  logic [2:0] ctrl_reg;
  logic [DATA_W-1:0] err_i_reg;
  logic [DATA_W-1:0] err_q_reg;
  logic [GROUP_W-1:0] prev_i_reg;
  logic [GROUP_W-1:0] prev_q_reg;
  logic prev_valid_reg;
  logic [CHIP_EVENTS-1:0] chip_clr_reg;
  logic [LANE_EVENTS-1:0] lane_clr_reg;
  logic [LINK_EVENTS-1:0] link_clr_reg;
  logic extra_clr_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic irq_oe_reg;
  logic [DATA_W-1:0] rd_next;

  logic chk_run;
  logic fail_i;
  logic fail_q;
  logic [CHIP_EVENTS-1:0] chip_ev;
  logic [CHIP_EVENTS-1:0] chip_src;
  logic [CHIP_EVENTS-1:0] chip_view;
  logic [LANE_EVENTS-1:0] lane_en;
  logic [LANE_EVENTS-1:0] lane_src;
  logic [LINK_EVENTS-1:0] link_en;
  logic [LINK_EVENTS-1:0] link_src;
  logic extra_src;
  logic [DATA_W-1:0] link_status;
  logic any_src;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Chip enables, readable back as stored
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      chip_en_reg <= {3{CHIP_EN_RST}};
    else if (reg_req.wr)
    begin
      for (int r = 0; r < 3; r++)
        if (reg_req.addr == ADDR_W'(CHIP_EVENT_ENABLE_A + r))
          chip_en_reg[r*DATA_W +: DATA_W] <= reg_req.wdata;
    end
  end

  // Link enables are write-only; the same address reads link status
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      link_en_reg <= LINK_EN_RST;
    else if (reg_req.wr && reg_req.addr == LINK_EVENT_ENABLE_STATUS)
      link_en_reg <= reg_req.wdata;
  end

  // Extra link event enable comes up set
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      extra_en_reg <= EXTRA_EN_RST;
    else if (reg_req.wr && reg_req.addr == LINK_EXTRA_EVENT_CTRL)
      extra_en_reg <= reg_req.wdata[EXTRA_EN_BIT];
  end

  // Checker control: enable, reset and pattern select
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      ctrl_reg <= CTRL_RST_VAL;
    else if (reg_req.wr && reg_req.addr == PATTERN_CHECK_CONTROL)
      ctrl_reg <= reg_req.wdata[2:0];
  end

  // ----------------------------------------------------------------
  // Clear strobes
  // ----------------------------------------------------------------
  // One-cycle pulses; clear bits never store a value
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      chip_clr_reg <= '0;
      lane_clr_reg <= '0;
      link_clr_reg <= '0;
      extra_clr_reg <= 1'b0;
    end
    else
    begin
      chip_clr_reg <= '0;
      lane_clr_reg <= '0;
      link_clr_reg <= '0;
      extra_clr_reg <= 1'b0;
      if (reg_req.wr)
      begin
        for (int r = 0; r < 3; r++)
          if (reg_req.addr == ADDR_W'(CHIP_EVENT_STATUS_A + r))
            chip_clr_reg[r*DATA_W +: DATA_W] <= reg_req.wdata;
        for (int r = 0; r < 3; r++)
          if (reg_req.addr == ADDR_W'(LANE_EVENT_CLEAR_FIRST + r))
            lane_clr_reg[r*LANES_PER_REG +: LANES_PER_REG] <=
              reg_req.wdata[LANES_PER_REG-1:0];
        for (int r = 0; r < 4; r++)
          if (reg_req.addr == ADDR_W'(LINK_EVENT_CLEAR_FIRST + r))
            link_clr_reg[r*LINKS_PER_REG +: LINKS_PER_REG] <=
              reg_req.wdata[LINKS_PER_REG-1:0];
        if (reg_req.addr == LINK_EXTRA_EVENT_CTRL)
          extra_clr_reg <= reg_req.wdata[EXTRA_ST_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Pattern checker
  // ----------------------------------------------------------------
  assign chk_run = ctrl_reg[CTRL_EN_BIT] & ~ctrl_reg[CTRL_RST_BIT];

  // Previous group held as the reference for the next one
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      prev_i_reg <= '0;
      prev_q_reg <= '0;
      prev_valid_reg <= 1'b0;
    end
    else if (!chk_run)
      prev_valid_reg <= 1'b0;
    else if (dp_group.valid)
    begin
      prev_i_reg <= dp_group.i;
      prev_q_reg <= dp_group.q;
      prev_valid_reg <= 1'b1;
    end
  end

  // Counts cleared by the checker reset, held while simply disabled
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      err_i_reg <= ERR_CNT_RST;
      err_q_reg <= ERR_CNT_RST;
    end
    else if (ctrl_reg[CTRL_RST_BIT])
    begin
      err_i_reg <= ERR_CNT_RST;
      err_q_reg <= ERR_CNT_RST;
    end
    else if (chk_run && dp_group.valid && prev_valid_reg)
    begin
      if (group_bad(prev_i_reg, dp_group.i, ctrl_reg[CTRL_SEL_BIT]))
        err_i_reg <= sat_inc(err_i_reg);
      if (group_bad(prev_q_reg, dp_group.q, ctrl_reg[CTRL_SEL_BIT]))
        err_q_reg <= sat_inc(err_q_reg);
    end
  end

  assign fail_i = |err_i_reg;
  assign fail_q = |err_q_reg;

  // ----------------------------------------------------------------
  // Event latches
  // ----------------------------------------------------------------
  // Checker failures replace two chip event inputs
  always_comb
  begin
    chip_ev = chip_event_in;
    chip_ev[CHIP_PRBS_I_IDX] = fail_i;
    chip_ev[CHIP_PRBS_Q_IDX] = fail_q;
  end

  // Each link enable bit gates one clear register's worth of events
  always_comb
  begin
    lane_en = '0;
    link_en = '0;
    for (int k = 0; k < LANE_EVENTS; k++)
      lane_en[k] = link_en_reg[LANE_EN_BASE + k / LANES_PER_REG];
    for (int k = 0; k < LINK_EVENTS; k++)
      link_en[k] = link_en_reg[LINK_EN_BASE + k / LINKS_PER_REG];
  end

  event_latch #(.N(CHIP_EVENTS)) u_chip (
    .clk(clk),
    .sys_rst(sys_rst),
    .event_in(chip_ev),
    .enable(chip_en_reg),
    .clear(chip_clr_reg),
    .source(chip_src)
  );

  event_latch #(.N(LANE_EVENTS)) u_lane (
    .clk(clk),
    .sys_rst(sys_rst),
    .event_in(lane_event_in),
    .enable(lane_en),
    .clear(lane_clr_reg),
    .source(lane_src)
  );

  event_latch #(.N(LINK_EVENTS)) u_link (
    .clk(clk),
    .sys_rst(sys_rst),
    .event_in(link_event_in),
    .enable(link_en),
    .clear(link_clr_reg),
    .source(link_src)
  );

  event_latch #(.N(1)) u_extra (
    .clk(clk),
    .sys_rst(sys_rst),
    .event_in(extra_event_in),
    .enable(extra_en_reg),
    .clear(extra_clr_reg),
    .source(extra_src)
  );

  // ----------------------------------------------------------------
  // Status views and request pin
  // ----------------------------------------------------------------
  // Chip view is live: source when enabled, raw event when not
  assign chip_view = (chip_en_reg & chip_src) | (~chip_en_reg & chip_ev);

  // Link status: sources are already zero while disabled
  always_comb
  begin
    link_status = '0;
    for (int g = 0; g < 3; g++)
      link_status[LANE_EN_BASE + g] = |lane_src[g*LANES_PER_REG +: LANES_PER_REG];
    for (int g = 0; g < 4; g++)
      link_status[LINK_EN_BASE + g] = |link_src[g*LINKS_PER_REG +: LINKS_PER_REG];
  end

  assign any_src = (|chip_src) | (|lane_src) | (|link_src) | extra_src;

  // Registered enable keeps the shared pin glitch free
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      irq_oe_reg <= 1'b0;
    else
      irq_oe_reg <= any_src;
  end

  assign irq_n_out = 1'b0;
  assign irq_n_oe = irq_oe_reg;

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  // Unmapped addresses read zero
  always_comb
  begin
    rd_next = '0;
    for (int r = 0; r < 3; r++)
    begin
      if (reg_req.addr == ADDR_W'(CHIP_EVENT_ENABLE_A + r))
        rd_next = chip_en_reg[r*DATA_W +: DATA_W];
      if (reg_req.addr == ADDR_W'(CHIP_EVENT_STATUS_A + r))
        rd_next = chip_view[r*DATA_W +: DATA_W];
    end
    case (reg_req.addr)
      PATTERN_CHECK_CONTROL:
        rd_next = {~fail_q, ~fail_i, 3'h0, ctrl_reg};
      PATTERN_ERRORS_I:
        rd_next = err_i_reg;
      PATTERN_ERRORS_Q:
        rd_next = err_q_reg;
      LINK_EVENT_ENABLE_STATUS:
        rd_next = link_status;
      LINK_EXTRA_EVENT_CTRL:
      begin
        rd_next[EXTRA_EN_BIT] = extra_en_reg;
        rd_next[EXTRA_ST_BIT] = extra_src;
      end
      default:
        ;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      rdata_reg <= '0;
    else if (reg_req.rd)
      rdata_reg <= rd_next;
  end

  assign reg_rdata = rdata_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_pin_low_only;
    irq_n_out == 1'b0;
  endproperty
  a_pin_low_only: assert property (p_pin_low_only) else $error("request pin driven high");

  property p_pull_follows;
    any_src |=> irq_n_oe;
  endproperty
  a_pull_follows: assert property (p_pull_follows) else $error("pending source not pulling");

  property p_idle_release;
    !any_src |=> !irq_n_oe;
  endproperty
  a_idle_release: assert property (p_idle_release) else $error("line pulled with no source");

  property p_one_per_group;
    ##1 (err_i_reg == $past(err_i_reg)) || (err_i_reg == DATA_W'($past(err_i_reg) + 1'b1))
      || (err_i_reg == '0);
  endproperty
  a_one_per_group: assert property (p_one_per_group) else $error("count jumped by more than one");

  property p_reset_clears;
    ctrl_reg[CTRL_RST_BIT] |=> (err_i_reg == '0) && (err_q_reg == '0);
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("checker reset kept counts");

  property p_pass_bits;
    (reg_req.rd && reg_req.addr == PATTERN_CHECK_CONTROL)
      |=> reg_rdata[CTRL_PASS_I_BIT] == ($past(err_i_reg) == '0);
  endproperty
  a_pass_bits: assert property (p_pass_bits) else $error("pass bit wrong");

  property p_chip_view;
    (reg_req.rd && reg_req.addr == CHIP_EVENT_STATUS_B) |=> reg_rdata[1:0] ==
      (($past(chip_en_reg[9:8]) & $past(chip_src[9:8])) |
       (~$past(chip_en_reg[9:8]) & $past(chip_ev[9:8])));
  endproperty
  a_chip_view: assert property (p_chip_view) else $error("chip status view wrong");

  // Strobe is high the cycle after the write and gone one cycle later
  property p_clear_pulse;
    (reg_req.wr && reg_req.addr == CHIP_EVENT_STATUS_B && reg_req.wdata[0])
      ##1 !reg_req.wr |-> chip_clr_reg[CHIP_PRBS_I_IDX] ##1 !chip_clr_reg[CHIP_PRBS_I_IDX];
  endproperty
  a_clear_pulse: assert property (p_clear_pulse) else $error("clear strobe not one cycle");

  // A group disabled now has its latched sources cleared by the next edge
  property p_link_disabled_zero;
    !link_en_reg[LANE_EN_BASE + 1] |=> !link_status[LANE_EN_BASE + 1];
  endproperty
  a_link_disabled_zero: assert property (p_link_disabled_zero) else $error("link status set");

  c_fail_i: cover property (chip_src[CHIP_PRBS_I_IDX] && irq_n_oe);
  c_fail_q: cover property (chip_src[CHIP_PRBS_Q_IDX]);
  c_cleared: cover property ($fell(chip_src[CHIP_PRBS_Q_IDX]));
  c_extra: cover property (extra_src ##1 extra_clr_reg);

endmodule : prbs_check_and_event_irq

// >>> rtl/prbs_irq_pkg.sv
// Shared constants and carrier types for the pattern checker and event request logic
package prbs_irq_pkg;

  // ----------------------------------------------------------------
  // Bus and datapath widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int GROUP_W = 32;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CHIP_EVENT_ENABLE_A = 12'h01F;
  localparam logic [ADDR_W-1:0] CHIP_EVENT_ENABLE_B = 12'h020;
  localparam logic [ADDR_W-1:0] CHIP_EVENT_ENABLE_C = 12'h021;
  localparam logic [ADDR_W-1:0] CHIP_EVENT_STATUS_A = 12'h023;
  localparam logic [ADDR_W-1:0] CHIP_EVENT_STATUS_B = 12'h024;
  localparam logic [ADDR_W-1:0] CHIP_EVENT_STATUS_C = 12'h025;
  localparam logic [ADDR_W-1:0] PATTERN_CHECK_CONTROL = 12'h14B;
  localparam logic [ADDR_W-1:0] PATTERN_ERRORS_I = 12'h14C;
  localparam logic [ADDR_W-1:0] PATTERN_ERRORS_Q = 12'h14D;
  localparam logic [ADDR_W-1:0] LANE_EVENT_CLEAR_FIRST = 12'h46D;
  localparam logic [ADDR_W-1:0] LANE_EVENT_CLEAR_LAST = 12'h46F;
  localparam logic [ADDR_W-1:0] LINK_EVENT_CLEAR_FIRST = 12'h470;
  localparam logic [ADDR_W-1:0] LINK_EVENT_CLEAR_LAST = 12'h473;
  localparam logic [ADDR_W-1:0] LINK_EVENT_ENABLE_STATUS = 12'h47A;
  localparam logic [ADDR_W-1:0] LINK_EXTRA_EVENT_CTRL = 12'h47B;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_RST_BIT = 1;
  localparam int CTRL_SEL_BIT = 2;
  localparam int CTRL_PASS_I_BIT = 6;
  localparam int CTRL_PASS_Q_BIT = 7;
  localparam int EXTRA_EN_BIT = 3;
  localparam int EXTRA_ST_BIT = 4;
  localparam int CHIP_PRBS_I_IDX = 8;
  localparam int CHIP_PRBS_Q_IDX = 9;

  // ----------------------------------------------------------------
  // Event counts and grouping
  // ----------------------------------------------------------------
  localparam int CHIP_EVENTS = 24;
  localparam int LANE_EVENTS = 12;
  localparam int LANES_PER_REG = 4;
  localparam int LINK_EVENTS = 8;
  localparam int LINKS_PER_REG = 2;
  localparam int LANE_EN_BASE = 0;
  localparam int LINK_EN_BASE = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] CHIP_EN_RST = 8'h00;
  localparam logic [DATA_W-1:0] LINK_EN_RST = 8'h00;
  localparam logic EXTRA_EN_RST = 1'b1;
  localparam logic [2:0] CTRL_RST_VAL = 3'h0;
  localparam logic [DATA_W-1:0] ERR_CNT_RST = 8'h00;

  // ----------------------------------------------------------------
  // Pattern feedback taps
  // ----------------------------------------------------------------
  localparam int PRBS7_TAP_A = 7;
  localparam int PRBS7_TAP_B = 6;
  localparam int PRBS15_TAP_A = 15;
  localparam int PRBS15_TAP_B = 14;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic valid;
    logic [GROUP_W-1:0] i;
    logic [GROUP_W-1:0] q;
  } dp_group_s;

endpackage : prbs_irq_pkg

// >>> rtl/event_latch.sv
// Edge-triggered latched interrupt sources for a group of events
`timescale 1ns/100ps
module event_latch #(
  parameter int N = 1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [N-1:0] event_in,
  input wire logic [N-1:0] enable,
  input wire logic [N-1:0] clear,
  output logic [N-1:0] source
);

  logic [N-1:0] prev_reg;
  logic [N-1:0] source_reg;
  logic [N-1:0] rise;

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  // Previous event level, tracked even while disabled so enabling is not an edge
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      prev_reg <= '0;
    else
      prev_reg <= event_in;
  end

  assign rise = event_in & ~prev_reg;

  // ----------------------------------------------------------------
  // Latched sources
  // ----------------------------------------------------------------
  // Set beats clear so an edge in the clear cycle is never lost
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      source_reg <= '0;
    else
      source_reg <= enable & ((source_reg & ~clear) | rise);
  end

  assign source = source_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_disabled_zero;
    !enable[0] |=> !source[0];
  endproperty
  a_disabled_zero: assert property (p_disabled_zero) else $error("source set while disabled");

  property p_edge_sets;
    (enable[0] && $rose(event_in[0])) |=> source[0];
  endproperty
  a_edge_sets: assert property (p_edge_sets) else $error("rising event did not latch");

  property p_holds;
    (source[0] && !clear[0] && enable[0]) |=> source[0];
  endproperty
  a_holds: assert property (p_holds) else $error("source dropped without clear");

endmodule : event_latch

// >>> sim/irq_pullup_host.sv
// Host side of the shared request line: pull-up and wired connection
`timescale 1ns/100ps
module irq_pullup_host (
  input wire logic irq_n_out,
  input wire logic irq_n_oe,
  output logic irq_line
);
  // ----------------------------------------------------------------
  // Line resolution
  // ----------------------------------------------------------------
  // The device may only pull low; a released line rises to the pull-up
  assign irq_line = irq_n_oe ? irq_n_out : 1'b1;
endmodule : irq_pullup_host

// >>> sim/tb_prbs_check_and_event_irq.sv
// Self-checking bench for the pattern checker and event request logic
`timescale 1ns/100ps
module tb_prbs_check_and_event_irq;
  import prbs_irq_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk;
  logic sys_rst;
  reg_req_s req;
  dp_group_s dp;
  logic [DATA_W-1:0] rdata;
  logic [CHIP_EVENTS-1:0] chip_ev;
  logic [LANE_EVENTS-1:0] lane_ev;
  logic [LINK_EVENTS-1:0] link_ev;
  logic extra_ev;
  logic irq_out;
  logic irq_oe;
  logic irq_line;
  logic [14:0] hi;
  logic [14:0] hq;
  logic [31:0] gi;
  logic [31:0] gq;
  int err_total;
  int total_checks;

  prbs_check_and_event_irq i_dut (.clk(clk), .sys_rst(sys_rst), .reg_req(req),
    .reg_rdata(rdata), .dp_group(dp), .chip_event_in(chip_ev), .lane_event_in(lane_ev),
    .link_event_in(link_ev), .extra_event_in(extra_ev), .irq_n_out(irq_out),
    .irq_n_oe(irq_oe));
  irq_pullup_host i_host (.irq_n_out(irq_out), .irq_n_oe(irq_oe), .irq_line(irq_line));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    if (err_total == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle

  // Strobe lasts one cycle so a clear acts once
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req.wr = 1'b0;
  endtask : wr

  // Data is sampled one and a half cycles after the read edge, where it has settled
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    req.rd = 1'b0;
    @(negedge clk);
    check($sformatf("reg %h", a), rdata, exp);
  endtask : rd

  task automatic line(input logic exp);
    check("irq line", {7'h00, irq_line}, {7'h00, exp});
  endtask : line

  // Pattern source; h[0] is the newest bit, long picks the 15-bit taps
  task automatic gen(inout logic [14:0] h, input logic lng, output logic [31:0] g);
    for (int k = 0; k < 32; k++)
    begin
      g[k] = lng ? h[14] ^ h[13] : h[6] ^ h[5];
      h = {h[13:0], g[k]};
    end
  endtask : gen

  // Flipped bits corrupt only the wire copy, the source stream runs on
  task automatic send(input logic li, input logic lq, input logic [31:0] fq);
    gen(hi, li, gi);
    gen(hq, lq, gq);
    @(negedge clk);
    dp = '{valid: 1'b1, i: gi, q: gq ^ fq};
    @(negedge clk);
    dp.valid = 1'b0;
  endtask : send

  initial
  begin
    #200000;
    err_total++;
    conclude();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    err_total = 0;
    total_checks = 0;
    sys_rst = 1'b1;
    req = '0;
    dp = '0;
    chip_ev = '0;
    lane_ev = '0;
    link_ev = '0;
    extra_ev = 1'b0;
    hi = 15'h7FFF;
    hq = 15'h7FFF;
    idle(16);
    sys_rst = 1'b0;
    rd(12'h01F, 8'h00);
    rd(12'h47B, 8'h08);
    rd(12'h14B, 8'hC0);
    rd(12'h100, 8'h00);
    line(1'b1);
    // Single bad bit, then ten bad bits: one count per affected group
    wr(12'h020, 8'h03);
    wr(12'h14B, 8'h03);
    wr(12'h14B, 8'h01);
    send(0, 0, '0);
    send(0, 0, '0);
    send(0, 0, 32'h80000000);
    send(0, 0, '0);
    send(0, 0, 32'hFFC00000);
    send(0, 0, '0);
    send(0, 0, '0);
    rd(12'h14C, 8'h00);
    rd(12'h14D, 8'h04);
    rd(12'h14B, 8'h41);
    for (int t = 0; t < 20 && irq_line !== 1'b0; t++) @(negedge clk);
    line(1'b0);
    // Service routine: read, disable, read live, fix, enable, clear
    rd(12'h024, 8'h02);
    wr(12'h020, 8'h01);
    idle(3);
    line(1'b1);
    rd(12'h024, 8'h02);
    wr(12'h14B, 8'h07);
    wr(12'h14B, 8'h05);
    repeat (5) send(1, 0, '0);
    rd(12'h14B, 8'h45);
    rd(12'h14C, 8'h00);
    wr(12'h020, 8'h03);
    wr(12'h024, 8'h03);
    rd(12'h024, 8'h00);
    line(1'b1);
    // Generic chip event: live view while disabled, latched when enabled
    chip_ev[0] = 1'b1;
    rd(12'h023, 8'h01);
    line(1'b1);
    chip_ev[0] = 1'b0;
    wr(12'h01F, 8'h01);
    rd(12'h01F, 8'h01);
    chip_ev[0] = 1'b1;
    idle(2);
    chip_ev[0] = 1'b0;
    idle(3);
    line(1'b0);
    rd(12'h023, 8'h01);
    wr(12'h023, 8'h00);
    rd(12'h023, 8'h01);
    wr(12'h023, 8'h01);
    rd(12'h023, 8'h00);
    line(1'b1);
    // Lane, link and extra events read zero unless enabled
    lane_ev[5] = 1'b1;
    rd(12'h47A, 8'h00);
    lane_ev[5] = 1'b0;
    wr(12'h47A, 8'h02);
    lane_ev[5] = 1'b1;
    rd(12'h47A, 8'h02);
    wr(12'h46E, 8'h02);
    rd(12'h47A, 8'h00);
    wr(12'h47A, 8'h40);
    link_ev[7] = 1'b1;
    rd(12'h47A, 8'h40);
    wr(12'h473, 8'h02);
    rd(12'h47A, 8'h00);
    extra_ev = 1'b1;
    rd(12'h47B, 8'h18);
    wr(12'h47B, 8'h18);
    rd(12'h47B, 8'h08);
    wr(12'h47B, 8'h00);
    rd(12'h47B, 8'h00);
    conclude();
  end
endmodule : tb_prbs_check_and_event_irq
